// File: cpc_pkg.sv
package cpc_pkg;

   // register byte offsets on the bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_USER_IO = 8'h0C;
   localparam logic [7:0] ADDR_SCAN_LOAD = 8'h10;
   localparam logic [7:0] ADDR_SCAN_CAPT = 8'h14;

   // option bits, in the control register and in the loaded option set
   localparam int OPT_W = 5;
   localparam int OPT_AS_TRISTATE = 0;
   localparam int OPT_USER_CLK = 1;
   localparam int OPT_INIT_DONE = 2;
   localparam int OPT_GLOBAL_OE = 3;
   localparam int OPT_GLOBAL_CLR = 4;
   localparam logic [OPT_W-1:0] OPT_RESET = 5'h00;

   // command register bits
   localparam int CMD_FRAME = 0;
   localparam int CMD_DONE = 1;

   // optional pin indices
   localparam int PIN_W = 4;
   localparam int PIN_USER_CLK = 0;
   localparam int PIN_INIT_DONE = 1;
   localparam int PIN_GLOBAL_OE = 2;
   localparam int PIN_GLOBAL_CLR = 3;
   localparam int UIO_OE_LSB = 4;
   localparam logic [7:0] UIO_RESET = 8'h00;

   // synchroniser lanes
   localparam int SY_W = 7;
   localparam int SY_RESTART = 0;
   localparam int SY_USER_CLK = 1;
   localparam int SY_GLOBAL_OE = 2;
   localparam int SY_GLOBAL_CLR = 3;
   localparam int SY_TCK = 4;
   localparam int SY_TMS = 5;
   localparam int SY_TDI = 6;

   // initialization length and serial clock divider
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] INIT_CYCLES = 8'h40;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam int DIV_W = 2;
   localparam logic [DIV_W-1:0] DIV_ONE = 2'h1;

   // scan chain
   localparam int SCAN_W = 32;
   localparam int IR_W = 4;
   localparam logic [SCAN_W-1:0] SCAN_RESET = 32'h00000000;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   typedef enum logic [1:0] {
      CPC_CFG_RESET,
      CPC_CFG_LOAD,
      CPC_CFG_INIT,
      CPC_CFG_USER
   } cpc_cfg_e;

   typedef enum logic [3:0] {
      CPC_TLR, CPC_RTI, CPC_SEL_DR, CPC_CAP_DR, CPC_SH_DR, CPC_EX1_DR,
      CPC_PA_DR, CPC_EX2_DR, CPC_UPD_DR, CPC_SEL_IR, CPC_CAP_IR,
      CPC_SH_IR, CPC_EX1_IR, CPC_PA_IR, CPC_EX2_IR, CPC_UPD_IR
   } cpc_tap_e;

endpackage

// File: cpc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module cpc_sync #(
   parameter int W = 1
) (
   input wire logic hclk, // block clock
   input wire logic hresetn, // async reset, active low
   input wire logic [W-1:0] d, // asynchronous inputs
   output logic [W-1:0] q // synchronised levels
);

   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule // cpc_sync

`default_nettype wire

// File: cpc_top.sv
// Contract
// - AS pins tri-stated in user mode when that option is on.
// - Unused optional pins act as user I/O, tri-stated with pull-up during configuration.
// - User start-up clock option times initialization from that external clock.
// - Init-done pin stays high impedance during restart and start of configuration.
// - Init-done driven low once its enable bit loads in first frame.
// - Global output enable low tri-states every I/O; high leaves them programmed.
// - Global clear low clears every device register; high leaves them programmed.
// - TDI sampled at each TCK rising edge.
// - TDO updated with next bit at each TCK falling edge.
// - TDO high impedance whenever nothing is shifted out.
// - TMS sampled at TCK rise; TAP state changes on following fall.
`timescale 1ns/1ps
`default_nettype none

module cpc_top
   import cpc_pkg::*;
(
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic config_restart_n, // configuration restart pin
   input wire logic user_startup_clock, // optional start-up clock pin
   input wire logic global_output_enable, // optional output-enable pin
   input wire logic global_register_clear_n, // optional clear pin
   input wire logic tck, // scan clock pin
   input wire logic tms, // scan mode pin
   input wire logic tdi, // scan data in pin
   output logic tdo, // scan data out
   output logic tdo_oe, // scan data out enable
   output logic dclk_out, // serial config clock
   output logic dclk_oe, // its enable
   output logic serial_config_data_oe, // serial data pin enable
   output logic flash_chip_select_n, // flash select, active low
   output logic flash_chip_select_n_oe, // its enable
   output logic flash_command_out, // flash command line
   output logic flash_command_out_oe, // its enable
   output logic [cpc_pkg::PIN_W-1:0] opt_io_out, // optional pin levels
   output logic [cpc_pkg::PIN_W-1:0] opt_io_oe, // optional pin enables
   output logic [cpc_pkg::PIN_W-1:0] opt_io_pullup, // weak pull-up enables
   output logic user_mode, // device in user mode
   output logic global_clear_n // device-wide clear, active low
);
   import cpc_pkg::*;

   logic [SY_W-1:0] sy;
   logic usrclk_prev_q, tck_prev_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [OPT_W-1:0] ctrl_q, opts_q;
   logic frame_q;
   cpc_cfg_e cfg_q, cfg_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [DIV_W-1:0] div_q;
   logic [7:0] uio_q;
   logic [SCAN_W-1:0] scan_load_q, scan_q, capt_q;
   logic [IR_W-1:0] ir_q;
   cpc_tap_e tap_q;
   logic tms_q;

   // every pin passes two flops before anything looks at it
   cpc_sync #(.W(SY_W)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({tdi, tms, tck, global_register_clear_n, global_output_enable,
          user_startup_clock, config_restart_n}),
      .q(sy)
   );

   // edge detect on synchronised clocks
   wire usrclk_rise = sy[SY_USER_CLK] & ~usrclk_prev_q;
   wire tck_rise = sy[SY_TCK] & ~tck_prev_q;
   wire tck_fall = ~sy[SY_TCK] & tck_prev_q;
   wire restart = ~sy[SY_RESTART];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         usrclk_prev_q <= 1'b0;
         tck_prev_q <= 1'b0;
      end else begin
         usrclk_prev_q <= sy[SY_USER_CLK];
         tck_prev_q <= sy[SY_TCK];
      end
   end

   // bus decode: zero wait states, writes land in the data phase
   wire ahb_go = hsel & htrans[1] & hready;
   wire wr_ctrl = wr_pend_q & (wr_addr_q == ADDR_CTRL);
   wire wr_cmd = wr_pend_q & (wr_addr_q == ADDR_CMD);
   wire wr_uio = wr_pend_q & (wr_addr_q == ADDR_USER_IO);
   wire wr_scan = wr_pend_q & (wr_addr_q == ADDR_SCAN_LOAD);
   wire [7:0] rd_addr = haddr[7:0];
   wire [31:0] status_w = {9'h000, sy, cnt_q, opts_q, frame_q, cfg_q};
   wire [31:0] rd_mux =
      (rd_addr == ADDR_CTRL) ? {27'h0000000, ctrl_q} :
      (rd_addr == ADDR_STATUS) ? status_w :
      (rd_addr == ADDR_USER_IO) ? {24'h000000, uio_q} :
      (rd_addr == ADDR_SCAN_LOAD) ? scan_load_q :
      (rd_addr == ADDR_SCAN_CAPT) ? capt_q : WORD_ZERO;

   // read data is fetched at the address phase so it is a flop output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= ADDR_CTRL;
         hrdata <= WORD_ZERO;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_q <= ahb_go & hwrite;
         wr_addr_q <= rd_addr;
         hrdata <= (ahb_go & ~hwrite) ? rd_mux : hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // global clear, only honoured once its option is loaded
   // clear on low level
   wire gclr = opts_q[OPT_GLOBAL_CLR] & ~sy[SY_GLOBAL_CLR];
   wire goe_off = opts_q[OPT_GLOBAL_OE] & ~sy[SY_GLOBAL_OE];

   // control register and options; restart throws loaded options away
   // options load with the first frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= OPT_RESET;
         opts_q <= OPT_RESET;
         frame_q <= 1'b0;
      end else if (restart) begin
         opts_q <= OPT_RESET;
         frame_q <= 1'b0;
      end else begin
         ctrl_q <= wr_ctrl ? hwdata[OPT_W-1:0] : ctrl_q;
         if (wr_cmd & hwdata[CMD_FRAME] & (cfg_q == CPC_CFG_LOAD) & ~frame_q) begin
            opts_q <= ctrl_q;
            frame_q <= 1'b1;
         end
      end
   end

   // initialization tick: external start-up clock or own clock
   // timing from the user start-up clock
   wire init_tick = opts_q[OPT_USER_CLK] ? usrclk_rise : 1'b1;
   wire load_done = wr_cmd & hwdata[CMD_DONE] & frame_q;

   // configuration sequence
   // fixed count before release
   always_comb begin
      cfg_d = cfg_q;
      cnt_d = cnt_q;
      case (cfg_q)
         CPC_CFG_RESET: begin
            cfg_d = CPC_CFG_LOAD;
            cnt_d = CNT_ZERO;
         end
         CPC_CFG_LOAD: begin
            if (load_done) begin
               cfg_d = CPC_CFG_INIT;
            end
         end
         CPC_CFG_INIT: begin
            if (init_tick) begin
               cnt_d = cnt_q + CNT_ONE;
               if (cnt_q == INIT_CYCLES - CNT_ONE) begin
                  cfg_d = CPC_CFG_USER;
               end
            end
         end
         CPC_CFG_USER: begin
            cfg_d = CPC_CFG_USER;
         end
         default: begin
            cfg_d = CPC_CFG_RESET;
         end
      endcase
      if (restart) begin
         cfg_d = CPC_CFG_RESET;
         cnt_d = CNT_ZERO;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= CPC_CFG_RESET;
         cnt_q <= CNT_ZERO;
      end else begin
         cfg_q <= cfg_d;
         cnt_q <= cnt_d;
      end
   end

   // user registers, wiped by the global clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         uio_q <= UIO_RESET;
         scan_load_q <= SCAN_RESET;
      end else if (gclr) begin
         uio_q <= UIO_RESET;
         scan_load_q <= SCAN_RESET;
      end else begin
         uio_q <= wr_uio ? hwdata[7:0] : uio_q;
         scan_load_q <= wr_scan ? hwdata : scan_load_q;
      end
   end

   // optional pin drive: user I/O only in user mode with option off
   wire in_user = (cfg_q == CPC_CFG_USER);
   wire in_cfg = (cfg_q == CPC_CFG_LOAD) | (cfg_q == CPC_CFG_INIT);
   wire [PIN_W-1:0] opt_on = {opts_q[OPT_GLOBAL_CLR], opts_q[OPT_GLOBAL_OE],
                              opts_q[OPT_INIT_DONE], opts_q[OPT_USER_CLK]};
   // unused optional pins as user I/O
   wire [PIN_W-1:0] uio_oe = {PIN_W{in_user & ~goe_off}} & ~opt_on &
                             uio_q[UIO_OE_LSB +: PIN_W];
   // released in restart and before the frame
   // driven low after the enable bit loads
   // released once user mode is reached
   wire init_low = opts_q[OPT_INIT_DONE] & frame_q & in_cfg;
   wire [PIN_W-1:0] opt_oe_d = {uio_oe[3:2], uio_oe[1] | init_low, uio_oe[0]};
   wire [PIN_W-1:0] opt_out_d = {uio_q[3:2], uio_q[1] & ~opt_on[PIN_INIT_DONE], uio_q[0]};
   // weak pull-up on undriven pins while not in user mode
   wire [PIN_W-1:0] pull_d = {PIN_W{~in_user}} & ~opt_oe_d;

   // active serial pins: clocked during loading, parked or released after
   // released in user mode with option on
   wire as_off = in_user & (opts_q[OPT_AS_TRISTATE] | goe_off);
   wire as_run = (cfg_q == CPC_CFG_LOAD);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= '0;
         dclk_out <= 1'b0;
         dclk_oe <= 1'b0;
         serial_config_data_oe <= 1'b0;
         flash_chip_select_n <= 1'b1;
         flash_chip_select_n_oe <= 1'b0;
         flash_command_out <= 1'b1;
         flash_command_out_oe <= 1'b0;
      end else begin
         div_q <= as_run ? div_q + DIV_ONE : '0;
         dclk_out <= as_run & div_q[DIV_W-1];
         dclk_oe <= ~as_off & ~restart;
         serial_config_data_oe <= 1'b0;
         flash_chip_select_n <= ~as_run;
         flash_chip_select_n_oe <= ~as_off & ~restart;
         flash_command_out <= 1'b1;
         flash_command_out_oe <= ~as_off & ~restart;
      end
   end

   // pin outputs and status flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opt_io_out <= '0;
         opt_io_oe <= '0;
         opt_io_pullup <= '1;
         user_mode <= 1'b0;
         global_clear_n <= 1'b1;
      end else begin
         opt_io_out <= opt_out_d;
         opt_io_oe <= opt_oe_d;
         opt_io_pullup <= pull_d;
         user_mode <= in_user;
         global_clear_n <= ~gclr;
      end
   end

   // scan controller next state for a given mode bit
   function automatic cpc_tap_e tap_next(input cpc_tap_e s, input logic m);
      case (s)
         CPC_TLR: tap_next = m ? CPC_TLR : CPC_RTI;
         CPC_RTI: tap_next = m ? CPC_SEL_DR : CPC_RTI;
         CPC_SEL_DR: tap_next = m ? CPC_SEL_IR : CPC_CAP_DR;
         CPC_CAP_DR: tap_next = m ? CPC_EX1_DR : CPC_SH_DR;
         CPC_SH_DR: tap_next = m ? CPC_EX1_DR : CPC_SH_DR;
         CPC_EX1_DR: tap_next = m ? CPC_UPD_DR : CPC_PA_DR;
         CPC_PA_DR: tap_next = m ? CPC_EX2_DR : CPC_PA_DR;
         CPC_EX2_DR: tap_next = m ? CPC_UPD_DR : CPC_SH_DR;
         CPC_UPD_DR: tap_next = m ? CPC_SEL_DR : CPC_RTI;
         CPC_SEL_IR: tap_next = m ? CPC_TLR : CPC_CAP_IR;
         CPC_CAP_IR: tap_next = m ? CPC_EX1_IR : CPC_SH_IR;
         CPC_SH_IR: tap_next = m ? CPC_EX1_IR : CPC_SH_IR;
         CPC_EX1_IR: tap_next = m ? CPC_UPD_IR : CPC_PA_IR;
         CPC_PA_IR: tap_next = m ? CPC_EX2_IR : CPC_PA_IR;
         CPC_EX2_IR: tap_next = m ? CPC_UPD_IR : CPC_SH_IR;
         CPC_UPD_IR: tap_next = m ? CPC_SEL_DR : CPC_RTI;
         default: tap_next = CPC_TLR;
      endcase
   endfunction

   wire shift_dr = (tap_q == CPC_SH_DR);
   wire shift_ir = (tap_q == CPC_SH_IR);
   wire cpc_tap_e tap_d = tap_next(tap_q, tms_q);

   // rising edge: take mode and data bits, shift the chains
   // data taken on rise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tms_q <= 1'b1;
         scan_q <= SCAN_RESET;
         ir_q <= IR_CAPTURE;
         capt_q <= SCAN_RESET;
      end else if (tck_rise) begin
         tms_q <= sy[SY_TMS];
         if (tap_q == CPC_CAP_DR) begin
            scan_q <= scan_load_q;
         end else if (shift_dr) begin
            scan_q <= {sy[SY_TDI], scan_q[SCAN_W-1:1]};
         end
         if (tap_q == CPC_CAP_IR) begin
            ir_q <= IR_CAPTURE;
         end else if (shift_ir) begin
            ir_q <= {sy[SY_TDI], ir_q[IR_W-1:1]};
         end
         capt_q <= (tap_q == CPC_UPD_DR) ? scan_q : capt_q;
      end
   end

   // falling edge: move the controller, present the next output bit
   // state changes on fall
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tap_q <= CPC_TLR;
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tap_q <= tap_d;
         tdo <= (tap_d == CPC_SH_IR) ? ir_q[0] : scan_q[0];
         tdo_oe <= (tap_d == CPC_SH_DR) | (tap_d == CPC_SH_IR);
      end
   end

   // hsize is unused: only whole-word accesses are expected
   wire unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:8]};

endmodule // cpc_top

`default_nettype wire

// File: cpc_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module cpc_monitor
   import cpc_pkg::*;
(
   input wire logic hclk, // bus clock
   input wire logic hresetn, // async reset
   input wire logic config_restart_n, // restart pin
   input wire logic global_register_clear_n, // clear pin
   input wire logic tck, // scan clock pin
   input wire logic tdo, // scan out
   input wire logic tdo_oe, // scan out enable
   input wire logic dclk_oe, // serial clock enable
   input wire logic flash_chip_select_n_oe, // select enable
   input wire logic flash_command_out_oe, // command enable
   input wire logic [cpc_pkg::PIN_W-1:0] opt_io_out, // pin levels
   input wire logic [cpc_pkg::PIN_W-1:0] opt_io_oe, // pin enables
   input wire logic [cpc_pkg::PIN_W-1:0] opt_io_pullup, // pull-ups
   input wire logic user_mode, // user mode
   input wire logic global_clear_n // device clear
);
   logic [7:0] rst_age_q, clr_age_q, rst_age_d, clr_age_d;

   // ages saturate so a long run never wraps into the window
   assign rst_age_d = !config_restart_n ? 8'h00 : rst_age_q + {7'h00, rst_age_q != 8'hFF};
   assign clr_age_d = !global_register_clear_n ? 8'h00 : clr_age_q + {7'h00, clr_age_q != 8'hFF};

   // cycles since each pin was last low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_age_q <= 8'h00;
         clr_age_q <= 8'hFF;
      end else begin
         rst_age_q <= rst_age_d;
         clr_age_q <= clr_age_d;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_restart_held;
      !config_restart_n [*6];
   endsequence
   sequence s_clear_off;
      global_register_clear_n [*6];
   endsequence

   property p_restart_quiet;
      s_restart_held |-> !opt_io_oe[PIN_INIT_DONE] && !user_mode;
   endproperty
   a_restart_quiet: assert property (p_restart_quiet)
      else $error("init-done driven in restart");
   property p_init_low;
      $rose(opt_io_oe[PIN_INIT_DONE]) && !user_mode |-> !opt_io_out[PIN_INIT_DONE];
   endproperty
   a_init_low: assert property (p_init_low)
      else $error("init-done not pulled low");
   property p_init_release;
      $fell(opt_io_oe[PIN_INIT_DONE]) && rst_age_q > 8'h06 |-> user_mode;
   endproperty
   a_init_release: assert property (p_init_release)
      else $error("init-done freed outside user mode");
   property p_user_hold;
      $fell(user_mode) |-> rst_age_q < 8'h07;
   endproperty
   a_user_hold: assert property (p_user_hold)
      else $error("user mode left without restart");
   property p_user_count;
      $rose(user_mode) |-> rst_age_q > 8'h41;
   endproperty
   a_user_count: assert property (p_user_count)
      else $error("user mode too early");
   property p_pullup;
      !user_mode && !$past(user_mode) |-> (opt_io_pullup | opt_io_oe) == 4'hF;
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("optional pin floating");
   property p_cfg_pins;
      !user_mode && !$past(user_mode) |-> (opt_io_oe & 4'hD) == 4'h0;
   endproperty
   a_cfg_pins: assert property (p_cfg_pins)
      else $error("optional pin driven in config");
   property p_as_group;
      dclk_oe == flash_chip_select_n_oe && dclk_oe == flash_command_out_oe;
   endproperty
   a_as_group: assert property (p_as_group)
      else $error("serial pins enabled apart");
   property p_tdo_fall;
      tdo_oe && $changed(tdo) |-> !tck;
   endproperty
   a_tdo_fall: assert property (p_tdo_fall)
      else $error("tdo moved while tck high");
   property p_oe_fall;
      $changed(tdo_oe) |-> !tck;
   endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("tdo enable moved while tck high");
   property p_clr_fall;
      $fell(global_clear_n) |-> clr_age_q < 8'h06;
   endproperty
   a_clr_fall: assert property (p_clr_fall)
      else $error("clear without pin");
   property p_clr_off;
      s_clear_off |-> global_clear_n;
   endproperty
   a_clr_off: assert property (p_clr_off)
      else $error("clear held after pin high");
endmodule // cpc_monitor

bind cpc_top cpc_monitor u_mon (
   .hclk(hclk), .hresetn(hresetn), .config_restart_n(config_restart_n),
   .global_register_clear_n(global_register_clear_n), .tck(tck), .tdo(tdo),
   .tdo_oe(tdo_oe), .dclk_oe(dclk_oe), .flash_chip_select_n_oe(flash_chip_select_n_oe),
   .flash_command_out_oe(flash_command_out_oe), .opt_io_out(opt_io_out),
   .opt_io_oe(opt_io_oe), .opt_io_pullup(opt_io_pullup), .user_mode(user_mode),
   .global_clear_n(global_clear_n)
);

`default_nettype wire

// File: cpc_scan_host.sv
`timescale 1ns/1ps
`default_nettype none

module cpc_scan_host (
   input wire logic hclk, // bench clock
   input wire logic start, // run one scan
   input wire logic [31:0] tdi_word, // data to shift in
   input wire logic tdo, // scan out
   input wire logic tdo_oe, // its enable
   output logic tck, // scan clock
   output logic tms, // mode select
   output logic tdi, // serial data
   output logic busy, // sequence running
   output logic [47:0] tdo_cap, // tdo per cycle
   output logic [47:0] oe_cap // enable per cycle
);
   // reset, idle, capture, 32 shifts, exit, update, idle
   localparam logic [47:0] TMS_SEQ = 48'h03000000005F;

   // idle levels: tck low, data lines high
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      busy = 1'b0;
   end

   // tck of 8 bench cycles; tdo read just before each fall
   always @(posedge hclk) begin
      if (start && !busy) begin
         busy <= 1'b1;
         for (int i = 0; i < 43; i++) begin
            // lines set up during low phase
            tms <= TMS_SEQ[i];
            tdi <= (i >= 9 && i <= 40) ? tdi_word[i-9] : 1'b1;
            repeat (4) @(posedge hclk);
            tck <= 1'b1;
            repeat (4) @(posedge hclk);
            // released line shows no stale level
            tdo_cap[i] <= tdo_oe ? tdo : ~tdo;
            oe_cap[i] <= tdo_oe;
            tck <= 1'b0;
         end
         busy <= 1'b0;
      end
   end
endmodule // cpc_scan_host

`default_nettype wire

// File: cpc_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   import cpc_pkg::*;
   typedef struct {logic [31:0] v; logic [31:0] m;} cpc_exp_s;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, scan_go = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, scan_d, scan_t;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic config_restart_n = 1'b0, user_startup_clock = 1'b0, global_output_enable = 1'b1;
   logic global_register_clear_n = 1'b1, rd_ph = 1'b0, init_prev = 1'b1;
   logic hreadyout, hresp, tdo, tdo_oe, dclk_out, dclk_oe, serial_config_data_oe, tck, tms, tdi;
   logic flash_chip_select_n, flash_chip_select_n_oe, flash_command_out, flash_command_out_oe;
   logic user_mode, global_clear_n, scan_busy;
   logic [PIN_W-1:0] opt_io_out, opt_io_oe, opt_io_pullup;
   logic [47:0] tdo_cap, oe_cap;
   int err_total = 0, comparisons = 0, init_rises = 0, n;
   cpc_exp_s exp_q[$];
   // open-drain status line with board pull-up
   wire logic init_done_w = opt_io_oe[PIN_INIT_DONE] ? opt_io_out[PIN_INIT_DONE] : 1'b1;

   cpc_top u_dut (.hready(hreadyout), .*);
   cpc_scan_host u_host (.hclk(hclk), .start(scan_go), .tdi_word(scan_t), .tdo(tdo),
      .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi), .busy(scan_busy),
      .tdo_cap(tdo_cap), .oe_cap(oe_cap));

   always #50 hclk = ~hclk;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cmp_rd(input logic [31:0] g);
      cpc_exp_s x;
      x = exp_q.pop_front();
      chk("hrdata", x.v, g & x.m);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tmo();
      err_total++;
      $display("MISMATCH wait exp done got hang");
      final_report();
   endtask
   // master waits for hready, never a fixed count
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 40);
      if (k >= 40) tmo();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back('{e & m, m});
      bus(1'b0, a, WORD_ZERO);
   endtask
   task automatic wait_user(output int k);
      k = 0;
      while (user_mode !== 1'b1 && k < 300) begin
         @(posedge hclk);
         k++;
      end
      if (k >= 300) tmo();
   endtask
   task automatic uclk(input int c);
      repeat (c) begin
         user_startup_clock <= 1'b1;
         repeat (4) @(posedge hclk);
         user_startup_clock <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask

   // read data checked in its data phase; status rises counted
   always @(posedge hclk) begin
      if (rd_ph) cmp_rd(hrdata);
      rd_ph <= hsel === 1'b1 && htrans === 2'h2 && hwrite === 1'b0 && hreadyout === 1'b1;
      if (init_done_w === 1'b1 && init_prev === 1'b0) init_rises++;
      init_prev <= init_done_w;
   end

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      void'($urandom(71));
      @(posedge hclk);
      chk("pullup", 32'hF, 32'(opt_io_pullup));
      chk("init oe", 32'h0, 32'(opt_io_oe));
      rd(ADDR_CTRL, WORD_ZERO, 32'hFFFFFFFF);
      rd(8'h18, WORD_ZERO, 32'hFFFFFFFF);
      $display("test reset done");
      config_restart_n <= 1'b1;
      repeat (4) @(posedge hclk);
      wr(ADDR_CTRL, 32'h0000001D);
      wr(ADDR_USER_IO, 32'h000000FF);
      @(posedge hclk);
      chk("load oe", 32'h0, 32'({opt_io_oe, flash_chip_select_n}));
      wr(ADDR_CMD, 32'h00000001);
      repeat (3) @(posedge hclk);
      chk("init drive", 32'h2, 32'(opt_io_oe));
      chk("init level", 32'h0, 32'(opt_io_out[PIN_INIT_DONE]));
      rd(ADDR_STATUS, 32'h00000005, 32'h00000007);
      wr(ADDR_CMD, 32'h00000002);
      wait_user(n);
      chk("init len", 32'h1, 32'(n >= 65 && n <= 67));
      chk("init free", 32'h0, 32'(opt_io_oe[PIN_INIT_DONE]));
      chk("as oe", 32'h0, 32'({dclk_oe, serial_config_data_oe, flash_command_out_oe,
         hresp}));
      repeat (2) @(posedge hclk);
      chk("rises", 32'h1, 32'(init_rises));
      chk("user io", 32'h1, 32'(opt_io_oe));
      global_output_enable <= 1'b0;
      repeat (5) @(posedge hclk);
      chk("oe low", 32'h0, 32'(opt_io_oe));
      global_output_enable <= 1'b1;
      repeat (5) @(posedge hclk);
      chk("oe high", 32'h1, 32'(opt_io_oe));
      global_register_clear_n <= 1'b0;
      repeat (5) @(posedge hclk);
      chk("clear", 32'h0, 32'(global_clear_n));
      global_register_clear_n <= 1'b1;
      repeat (5) @(posedge hclk);
      chk("clear off", 32'h1, 32'(global_clear_n));
      rd(ADDR_USER_IO, WORD_ZERO, 32'h000000FF);
      $display("test config done");
      config_restart_n <= 1'b0;
      repeat (6) @(posedge hclk);
      chk("restart", 32'h0, 32'({user_mode, opt_io_oe[PIN_INIT_DONE]}));
      config_restart_n <= 1'b1;
      repeat (4) @(posedge hclk);
      wr(ADDR_CTRL, 32'h00000006);
      wr(ADDR_CMD, 32'h00000001);
      wr(ADDR_CMD, 32'h00000002);
      repeat (100) @(posedge hclk);
      chk("no clock", 32'h0, 32'(user_mode));
      uclk(63);
      chk("63 ticks", 32'h0, 32'(user_mode));
      uclk(1);
      wait_user(n);
      chk("user clk", 32'h1, 32'(n < 12));
      chk("as on", 32'h1D, 32'({dclk_oe, flash_chip_select_n_oe, flash_command_out_oe,
         dclk_out, flash_command_out}));
      $display("test start clock done");
      scan_d = $urandom;
      scan_t = $urandom;
      wr(ADDR_SCAN_LOAD, scan_d);
      scan_go <= 1'b1;
      @(posedge hclk);
      scan_go <= 1'b0;
      @(posedge hclk);
      n = 0;
      while (scan_busy === 1'b1 && n < 600) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 600) tmo();
      chk("tdo bits", scan_d, tdo_cap[40:9]);
      chk("tdo oe", 32'hFFFFFFFF, oe_cap[40:9]);
      chk("tdo idle", 32'h0, 32'({oe_cap[41], oe_cap[8:0]}));
      rd(ADDR_SCAN_CAPT, scan_t, 32'hFFFFFFFF);
      $display("test scan done");
      @(posedge hclk);
      final_report();
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
endmodule // tb

`default_nettype wire
